// [shared/dtr_map.vh]
// register offsets, field positions and codes for the debug transfer block
`ifndef DTR_MAP_VH
`define DTR_MAP_VH

`define DTR_ADDR_W          12
`define DTR_OFF_EVENT_CATCH 12'h024
`define DTR_OFF_CACHE_CTRL  12'h028
`define DTR_OFF_MMU_CTRL    12'h02C
`define DTR_OFF_TO_CORE     12'h080
`define DTR_OFF_INJECT      12'h084
`define DTR_OFF_STATUS      12'h088
`define DTR_OFF_FROM_CORE   12'h08C
`define DTR_OFF_RUN_CTRL    12'h090
`define DTR_OFF_PC_SAMPLE   12'h0A0
`define DTR_OFF_OS_LOCK_ACC 12'h300
`define DTR_OFF_OS_LOCK_ST  12'h304
`define DTR_OFF_OS_SAVE     12'h308

`define DTR_ST_HALTED       0
`define DTR_ST_RESTARTED    1
`define DTR_ST_MOE_LO       2
`define DTR_ST_MOE_HI       5
`define DTR_ST_SYNC_ABT     6
`define DTR_ST_ASYNC_ABT    7
`define DTR_ST_UNDEF        8
`define DTR_ST_MODE_LO      20
`define DTR_ST_MODE_HI      21
`define DTR_ST_INSTR_DONE   24
`define DTR_ST_PIPE_ADV     25
`define DTR_ST_RX_LATCHED   26
`define DTR_ST_TX_LATCHED   27
`define DTR_ST_TX_PENDING   29
`define DTR_ST_RX_PENDING   30

`define DTR_RC_HALT         0
`define DTR_RC_RESTART      1
`define DTR_RC_CLR_EXC      2
`define DTR_RC_CLR_PIPE     3

`define DTR_MODE_NONBLOCK   2'h0
`define DTR_MODE_STALL      2'h1
`define DTR_MODE_FAST       2'h2

`define DTR_ISET_WIDE       2'h0
`define DTR_ISET_COMPACT    2'h1
`define DTR_ISET_COMPACT_EE 2'h2
`define DTR_ISET_BYTECODE   2'h3
`define DTR_CODE_WIDE       2'h0
`define DTR_CODE_COMPACT    2'h1
`define DTR_CODE_COMPACT_EE 2'h3
`define DTR_CODE_BYTECODE   2'h2

`define DTR_FIFO_WIDTH      32
`define DTR_FIFO_DEPTH      8
`define DTR_FIFO_AW         3

`endif

// [verif/dtr_dbg_model.sv]
// debugger model: apb master with status polling
`timescale 1ns/1ps
`default_nettype none
`include "dtr_map.vh"
module dtr_dbg_model (
    input  wire logic        CLK,
    input  wire logic        PREADY,
    input  wire logic [31:0] PRDATA,
    output logic             PSEL,
    output logic             PENABLE,
    output logic             PWRITE,
    output logic      [11:0] PADDR,
    output logic      [31:0] PWDATA
);
    initial {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output int w);
        w = 0;
        @(posedge CLK);
        {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, wr, a, d};
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
            w++;
        end while (PREADY !== 1'b1 && w < 300);
        q = PRDATA;
        // released lines flip, so stale values look wrong
        {PSEL, PENABLE, PADDR, PWDATA} <= {2'b00, ~a, ~d};
    endtask
    task automatic poll(input int b, output logic [31:0] q);
        int w;
        for (int i = 0; i < 20; i++) begin
            xfer(1'b0, `DTR_OFF_STATUS, 32'h0, q, w);
            if (q[b] === 1'b1)
                break;
        end
    endtask
endmodule
`default_nettype wire

// [verif/dtr_run_ctrl_monitor.sv]
// port-level assertions for the debug transfer block
`timescale 1ns/1ps
`default_nettype none
`include "dtr_map.vh"
module dtr_run_ctrl_monitor (
    input wire logic        CLK,
    input wire logic        RESET,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        CORE_HALTED,
    input wire logic        CORE_RX_READ,
    input wire logic        CORE_RX_PENDING,
    input wire logic        INSTR_ISSUE,
    input wire logic        HALT_REQ,
    input wire logic        RESTART_REQ
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    sequence s_setup;
        PSEL && !PENABLE ##1 PSEL && PENABLE;
    endsequence
    sequence s_done;
        PREADY ##1 !PREADY;
    endsequence

    chk_wait_state: assert property (s_setup |-> !PREADY)
        else $error("ready came without a wait state");
    chk_ready_pulse: assert property (
        PREADY |-> $past(PSEL && PENABLE) ##0 s_done)
        else $error("ready not one cycle");
    chk_no_error: assert property (PSLVERR == 1'b0)
        else $error("error response raised");
    chk_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside answer cycle");
    chk_issue_ack: assert property (INSTR_ISSUE |-> PREADY)
        else $error("issue without access");
    chk_rx_load: assert property (
        $rose(CORE_RX_PENDING) |->
        PREADY && $past(PWRITE && PADDR == `DTR_OFF_TO_CORE))
        else $error("to-core pending set without a write");
    chk_rx_consume: assert property (
        CORE_RX_READ && !(PSEL && PENABLE) |=> !CORE_RX_PENDING)
        else $error("core read left word pending");
    chk_halt_hold: assert property (
        HALT_REQ && !CORE_HALTED |=> HALT_REQ)
        else $error("halt request dropped early");
    chk_halt_state: assert property (CORE_HALTED |=> !HALT_REQ)
        else $error("halt request held in debug state");
    chk_restart_hold: assert property (
        RESTART_REQ && CORE_HALTED |=> RESTART_REQ)
        else $error("restart request dropped early");
    chk_restart_state: assert property (
        !CORE_HALTED |=> !RESTART_REQ)
        else $error("restart request held in normal state");
endmodule

bind dtr_run_ctrl dtr_run_ctrl_monitor i_mon (
    .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CORE_HALTED(CORE_HALTED),
    .CORE_RX_READ(CORE_RX_READ), .CORE_RX_PENDING(CORE_RX_PENDING),
    .INSTR_ISSUE(INSTR_ISSUE), .HALT_REQ(HALT_REQ),
    .RESTART_REQ(RESTART_REQ));
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the debug transfer block
`timescale 1ns/1ps
`default_nettype none
`include "dtr_map.vh"
module tb_top;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rx_data, instr_word, pc, tx_data;
    logic        halted, restarted, undef_e, async_e, sync_e, pipe_e;
    logic        rx_read, rx_pend, tx_valid, done, issue, halt_req, rst_req;
    logic [3:0]  moe;
    logic [1:0]  iset;
    logic [3:0]  dly = 4'h0;
    int          n_fail = 0, samples_checked = 0, n_issue = 0;

    dtr_run_ctrl i_dut (
        .CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CORE_HALTED(halted),
        .CORE_RESTARTED(restarted), .CORE_MOE(moe), .CORE_PC(pc),
        .CORE_ISET(iset), .CORE_UNDEF_EVT(undef_e),
        .CORE_ASYNC_ABT_EVT(async_e), .CORE_SYNC_ABT_EVT(sync_e),
        .CORE_PIPE_ADV_EVT(pipe_e), .CORE_RX_READ(rx_read),
        .CORE_RX_DATA(rx_data), .CORE_RX_PENDING(rx_pend),
        .CORE_TX_VALID(tx_valid), .CORE_TX_DATA(tx_data),
        .CORE_TX_READY(), .CORE_INSTR_DONE(done), .INSTR_ISSUE(issue),
        .INSTR_WORD(instr_word), .HALT_REQ(halt_req), .RESTART_REQ(rst_req));
    dtr_dbg_model i_dbg (
        .CLK(clk), .PREADY(pready), .PRDATA(prdata), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // core stand-in: op completes 5 cycles after issue
    always @(posedge clk) begin
        dly <= {dly[2:0], issue === 1'b1};
        done <= dly[3];
        if (issue === 1'b1)
            n_issue <= n_issue + 1;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        int w;
        i_dbg.xfer(1'b1, a, d, q, w);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        int w;
        i_dbg.xfer(1'b0, a, 32'h0, q, w);
    endtask
    task automatic consume;
        @(posedge clk) rx_read <= 1'b1;
        @(posedge clk) rx_read <= 1'b0;
    endtask
    task automatic push(input logic [31:0] d);
        @(posedge clk) tx_data <= d;
        tx_valid <= 1'b1;
        @(posedge clk) tx_valid <= 1'b0;
    endtask
    task automatic setmode(input logic [1:0] m);
        wr(`DTR_OFF_STATUS, {10'h000, m, 20'h00000});
    endtask

    task automatic t_reset;
        logic [31:0] q;
        rd(`DTR_OFF_STATUS, q);
        check(q[21:20], `DTR_MODE_NONBLOCK);
        check(q[1:0], 2'h2);
    endtask
    task automatic t_stubs;
        logic [11:0] a[7] = '{`DTR_OFF_EVENT_CATCH, `DTR_OFF_CACHE_CTRL,
            `DTR_OFF_MMU_CTRL, `DTR_OFF_OS_LOCK_ACC, `DTR_OFF_OS_LOCK_ST,
            `DTR_OFF_OS_SAVE, 12'h0FC};
        logic [31:0] q;
        foreach (a[i]) begin
            wr(a[i], 32'hFFFFFFFF);
            rd(a[i], q);
            check(q, 32'h0);
        end
    endtask
    task automatic t_pc;
        logic [1:0] code[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
        logic [31:0] q, v;
        for (int k = 0; k < 4; k++) begin
            v = 32'h87654323 + (k << 4);
            @(posedge clk) pc <= v;
            iset <= k[1:0];
            rd(`DTR_OFF_PC_SAMPLE, q);
            check(q, {v[31:2], code[k]});
        end
    endtask
    task automatic t_nonblock;
        logic [31:0] q;
        int n0;
        rd(`DTR_OFF_STATUS, q);
        wr(`DTR_OFF_TO_CORE, 32'h11110001);
        wr(`DTR_OFF_TO_CORE, 32'h22220002);
        check(rx_data, 32'h11110001);
        consume;
        wr(`DTR_OFF_TO_CORE, 32'h22220002);
        check(rx_pend, 1'b0);
        rd(`DTR_OFF_STATUS, q);
        check(q[26], 1'b0);
        wr(`DTR_OFF_TO_CORE, 32'h33330003);
        check(rx_data, 32'h33330003);
        consume;
        n0 = n_issue;
        rd(`DTR_OFF_STATUS, q);
        wr(`DTR_OFF_INJECT, 32'hE0000001);
        wr(`DTR_OFF_INJECT, 32'hE0000002);
        repeat (2) @(posedge clk);
        check(n_issue - n0, 1);
        check(instr_word, 32'hE0000001);
        push(32'hC0DE0004);
        rd(`DTR_OFF_FROM_CORE, q);
        rd(`DTR_OFF_STATUS, q);
        check(q[29:26], 4'hA);
        rd(`DTR_OFF_FROM_CORE, q);
        check(q, 32'hC0DE0004);
    endtask
    task automatic t_stall;
        logic [31:0] q;
        int w, n0;
        setmode(`DTR_MODE_STALL);
        rd(`DTR_OFF_STATUS, q);
        check(q[21:20], `DTR_MODE_STALL);
        wr(`DTR_OFF_TO_CORE, 32'h44440001);
        fork
            i_dbg.xfer(1'b1, `DTR_OFF_TO_CORE, 32'h55550002, q, w);
            begin
                repeat (10) @(posedge clk);
                consume;
            end
        join
        check(w >= 10 && w < 16, 1'b1);
        check(rx_data, 32'h55550002);
        consume;
        fork
            i_dbg.xfer(1'b0, `DTR_OFF_FROM_CORE, 32'h0, q, w);
            begin
                repeat (8) @(posedge clk);
                push(32'h66660003);
            end
        join
        check(q, 32'h66660003);
        check(w >= 8 && w < 14, 1'b1);
        n0 = n_issue;
        wr(`DTR_OFF_INJECT, 32'hE0000003);
        i_dbg.xfer(1'b1, `DTR_OFF_INJECT, 32'hE0000004, q, w);
        check(w >= 4, 1'b1);
        repeat (8) @(posedge clk);
        check(n_issue - n0, 2);
        check(instr_word, 32'hE0000004);
    endtask
    task automatic t_fast;
        logic [31:0] q;
        int n0;
        setmode(`DTR_MODE_FAST);
        n0 = n_issue;
        wr(`DTR_OFF_INJECT, 32'hF0000001);
        wr(`DTR_OFF_TO_CORE, 32'h77770001);
        repeat (2) @(posedge clk);
        check(n_issue - n0, 1);
        check(instr_word, 32'hF0000001);
        consume;
        push(32'h88880002);
        rd(`DTR_OFF_FROM_CORE, q);
        repeat (2) @(posedge clk);
        check({q, n_issue - n0}, {32'h88880002, 32'h2});
        repeat (6) @(posedge clk);
        @(posedge clk) sync_e <= 1'b1;
        @(posedge clk) sync_e <= 1'b0;
        wr(`DTR_OFF_TO_CORE, 32'h99990003);
        wr(`DTR_OFF_INJECT, 32'hF0000002);
        repeat (2) @(posedge clk);
        check({rx_pend, n_issue - n0}, {1'b0, 32'h2});
        @(posedge clk) {undef_e, async_e, pipe_e} <= 3'h7;
        @(posedge clk) {undef_e, async_e, pipe_e} <= 3'h0;
        wr(`DTR_OFF_RUN_CTRL, 32'h4);
        rd(`DTR_OFF_STATUS, q);
        check({q[25], q[8:6]}, 4'h8);
        wr(`DTR_OFF_RUN_CTRL, 32'h8);
        rd(`DTR_OFF_STATUS, q);
        check(q[25], 1'b0);
        setmode(`DTR_MODE_NONBLOCK);
    endtask
    task automatic t_run;
        logic [31:0] q;
        wr(`DTR_OFF_RUN_CTRL, 32'h2);
        check(rst_req, 1'b0);
        wr(`DTR_OFF_RUN_CTRL, 32'h1);
        check(halt_req, 1'b1);
        rd(`DTR_OFF_RUN_CTRL, q);
        check({q, halt_req}, 33'h1);
        @(posedge clk) halted <= 1'b1;
        i_dbg.poll(0, q);
        check({q[0], halt_req}, 2'h2);
        wr(`DTR_OFF_RUN_CTRL, 32'h1);
        check(halt_req, 1'b0);
        wr(`DTR_OFF_RUN_CTRL, 32'h2);
        @(posedge clk) restarted <= 1'b0;
        rd(`DTR_OFF_RUN_CTRL, q);
        check({q, rst_req}, 33'h1);
        rd(`DTR_OFF_STATUS, q);
        check(q[1:0], 2'h1);
        @(posedge clk) halted <= 1'b0;
        restarted <= 1'b1;
        i_dbg.poll(1, q);
        check({q[1:0], rst_req}, 3'h4);
    endtask

    task automatic report_and_stop;
        if (n_fail == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        {halted, undef_e, async_e, sync_e, pipe_e, rx_read, tx_valid} = '0;
        {moe, iset, pc, tx_data} = '0;
        restarted = 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        t_reset;
        t_stubs;
        t_pc;
        t_nonblock;
        t_stall;
        t_fast;
        t_run;
        report_and_stop;
    end
    // run needs under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop;
    end
endmodule
`default_nettype wire

// [verilog/dtr_run_ctrl.v]
// debug transfer, instruction injection and run control behind APB
`timescale 1ns/1ps
`default_nettype none
`include "dtr_map.vh"

module dtr_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             reset,
    input  wire             in_valid,
    output reg              in_ready,
    input  wire [WIDTH-1:0] in_data,
    output reg              out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    reg [AW:0]      next_count;
    wire            push;
    wire            pop;

    assign push     = in_valid & in_ready;
    assign pop      = out_valid & out_ready;
    assign out_data = mem[rd_ptr];

    always @* begin
        next_count = count;
        if (push & ~pop) begin
            next_count = count + {{AW{1'b0}}, 1'b1};
        end else if (pop & ~push) begin
            next_count = count - {{AW{1'b0}}, 1'b1};
        end
    end

    // flags from next count, so both sides see flops
    always @(posedge clk) begin
        if (reset) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            count     <= next_count;
            in_ready  <= (next_count != DEPTH[AW:0]);
            out_valid <= (next_count != {(AW+1){1'b0}});
        end
    end

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

// Notes on behaviour
// - mode field picks nonblocking, stall, fast; nonblocking reset
// - nonblocking: drop to-core write if latched pending
// - nonblocking: drop injection write unless latched done
// - nonblocking: empty from-core read has no effect
// - status read latches pending flags, sets done
// - stall: to-core write waits for pending clear
// - stall: injection write waits for op done
// - stall: from-core read waits for pending set
// - fast: data transfer issues held injected instruction
// - stall, nonblocking: injection write issues instruction
// - pc sample holds pc bits 31 to 2
// - low pc sample bits encode instruction set
// - only memory-mapped pc sample must be valid
// - cache, event catch, mmu controls read zero
// - os lock and save registers zero, ignore writes
// - run control bit 3 clears pipeline advance
// - run control bit 2 clears exception flags
// - restart request held until debug exit
// - halt request held until debug entry
// - sync abort blocks injection and fast transfers
// - halted bit follows debug state
// - restarted bit follows exit progress
module dtr_run_ctrl (
    input  wire        CLK,
    input  wire        RESET,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    input  wire        CORE_HALTED,
    input  wire        CORE_RESTARTED,
    input  wire [3:0]  CORE_MOE,
    input  wire [31:0] CORE_PC,
    input  wire [1:0]  CORE_ISET,
    input  wire        CORE_UNDEF_EVT,
    input  wire        CORE_ASYNC_ABT_EVT,
    input  wire        CORE_SYNC_ABT_EVT,
    input  wire        CORE_PIPE_ADV_EVT,
    input  wire        CORE_RX_READ,
    output reg  [31:0] CORE_RX_DATA,
    output reg         CORE_RX_PENDING,
    input  wire        CORE_TX_VALID,
    input  wire [31:0] CORE_TX_DATA,
    output wire        CORE_TX_READY,
    input  wire        CORE_INSTR_DONE,
    output reg         INSTR_ISSUE,
    output reg  [31:0] INSTR_WORD,
    output reg         HALT_REQ,
    output reg         RESTART_REQ
);
    localparam ST_IDLE = 2'b01;
    localparam ST_DONE = 2'b10;

    reg  [1:0]  state;
    reg  [1:0]  mode;
    reg  [31:0] itr;
    reg         instr_done;
    reg         rx_latched;
    reg         tx_latched;
    reg         done_latched;
    reg         sync_abt;
    reg         async_abt;
    reg         undef_exc;
    reg         pipe_adv;
    reg  [31:0] pc_sample;
    reg  [1:0]  iset_code;

    reg         go;
    reg         do_rx_wr;
    reg         do_itr_wr;
    reg         do_tx_pop;
    reg         do_issue;
    reg         do_status_rd;
    reg         do_mode_wr;
    reg         do_run_wr;
    reg  [31:0] rd_value;
    reg  [31:0] status_word;

    wire        tx_pending;
    wire [31:0] tx_data;
    wire        access;
    wire        m_stall;
    wire        m_fast;

    dtr_fifo #(
        .WIDTH (`DTR_FIFO_WIDTH),
        .DEPTH (`DTR_FIFO_DEPTH),
        .AW    (`DTR_FIFO_AW)
    ) u_from_core (
        .clk       (CLK),
        .reset     (RESET),
        .in_valid  (CORE_TX_VALID),
        .in_ready  (CORE_TX_READY),
        .in_data   (CORE_TX_DATA),
        .out_valid (tx_pending),
        .out_ready (do_tx_pop),
        .out_data  (tx_data)
    );

    assign access  = PSEL & PENABLE & state[0];
    // reserved mode code acts as nonblocking
    assign m_stall = (mode == `DTR_MODE_STALL);
    assign m_fast  = (mode == `DTR_MODE_FAST);

    always @* begin
        status_word = 32'h0000_0000;
        status_word[`DTR_ST_HALTED]     = CORE_HALTED;
        status_word[`DTR_ST_RESTARTED]  = CORE_RESTARTED;
        status_word[`DTR_ST_MOE_HI:`DTR_ST_MOE_LO] = CORE_MOE;
        status_word[`DTR_ST_SYNC_ABT]   = sync_abt;
        status_word[`DTR_ST_ASYNC_ABT]  = async_abt;
        status_word[`DTR_ST_UNDEF]      = undef_exc;
        status_word[`DTR_ST_MODE_HI:`DTR_ST_MODE_LO] = mode;
        status_word[`DTR_ST_INSTR_DONE] = instr_done;
        status_word[`DTR_ST_PIPE_ADV]   = pipe_adv;
        // a status read returns the copy it takes, so show live flags
        status_word[`DTR_ST_RX_LATCHED] = CORE_RX_PENDING;
        status_word[`DTR_ST_TX_LATCHED] = tx_pending;
        status_word[`DTR_ST_TX_PENDING] = tx_pending;
        status_word[`DTR_ST_RX_PENDING] = CORE_RX_PENDING;
    end

    // does the access complete now, and with what effect
    always @* begin
        go           = 1'b0;
        do_rx_wr     = 1'b0;
        do_itr_wr    = 1'b0;
        do_tx_pop    = 1'b0;
        do_issue     = 1'b0;
        do_status_rd = 1'b0;
        do_mode_wr   = 1'b0;
        do_run_wr    = 1'b0;
        rd_value     = 32'h0000_0000;
        if (access) begin
            go = 1'b1;
            case (PADDR)
                `DTR_OFF_TO_CORE: begin
                    if (PWRITE) begin
                        if (m_fast) begin
                            if (!sync_abt) begin
                                go = ~CORE_RX_PENDING & instr_done;
                                do_rx_wr = go;
                                do_issue = go;
                            end
                        end else if (m_stall) begin
                            go = ~CORE_RX_PENDING;
                            do_rx_wr = go;
                        end else begin
                            do_rx_wr = ~rx_latched;
                        end
                    end
                end
                `DTR_OFF_INJECT: begin
                    if (PWRITE && !sync_abt) begin
                        if (m_stall) begin
                            go = instr_done;
                            do_itr_wr = go;
                            do_issue  = go;
                        end else if (m_fast) begin
                            // fast mode only stores the word
                            do_itr_wr = 1'b1;
                        end else begin
                            do_itr_wr = done_latched;
                            do_issue  = done_latched;
                        end
                    end
                end
                `DTR_OFF_FROM_CORE: begin
                    if (!PWRITE) begin
                        if (m_fast) begin
                            if (!sync_abt) begin
                                go = tx_pending & instr_done;
                                do_tx_pop = go;
                                do_issue  = go;
                            end
                        end else if (m_stall) begin
                            go = tx_pending;
                            do_tx_pop = go;
                        end else begin
                            do_tx_pop = tx_latched;
                        end
                        if (do_tx_pop) begin
                            rd_value = tx_data;
                        end
                    end
                end
                `DTR_OFF_STATUS: begin
                    do_status_rd = ~PWRITE;
                    do_mode_wr   = PWRITE;
                    rd_value     = status_word;
                end
                `DTR_OFF_RUN_CTRL: begin
                    // write-only: reads zero
                    do_run_wr = PWRITE;
                end
                `DTR_OFF_PC_SAMPLE: begin
                    rd_value = pc_sample;
                end
                `DTR_OFF_EVENT_CATCH,
                `DTR_OFF_CACHE_CTRL,
                `DTR_OFF_MMU_CTRL: begin
                    rd_value = 32'h0000_0000;
                end
                `DTR_OFF_OS_LOCK_ACC,
                `DTR_OFF_OS_LOCK_ST,
                `DTR_OFF_OS_SAVE: begin
                    rd_value = 32'h0000_0000;
                end
                default: begin
                    rd_value = 32'h0000_0000;
                end
            endcase
        end
    end

    always @* begin
        case (CORE_ISET)
            `DTR_ISET_WIDE:       iset_code = `DTR_CODE_WIDE;
            `DTR_ISET_COMPACT:    iset_code = `DTR_CODE_COMPACT;
            `DTR_ISET_COMPACT_EE: iset_code = `DTR_CODE_COMPACT_EE;
            default:              iset_code = `DTR_CODE_BYTECODE;
        endcase
    end

    // bus handshake: every transfer takes at least one wait state
    always @(posedge CLK) begin
        if (RESET) begin
            state   <= ST_IDLE;
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (go) begin
                        state  <= ST_DONE;
                        PREADY <= 1'b1;
                        PRDATA <= PWRITE ? 32'h0000_0000 : rd_value;
                    end
                end
                ST_DONE: begin
                    state  <= ST_IDLE;
                    PREADY <= 1'b0;
                    PRDATA <= 32'h0000_0000;
                end
                default: begin
                    state  <= ST_IDLE;
                    PREADY <= 1'b0;
                end
            endcase
        end
    end

    always @(posedge CLK) begin
        if (RESET) begin
            mode            <= `DTR_MODE_NONBLOCK;
            itr             <= 32'h0000_0000;
            instr_done      <= 1'b1;
            rx_latched      <= 1'b0;
            tx_latched      <= 1'b0;
            done_latched    <= 1'b1;
            CORE_RX_DATA    <= 32'h0000_0000;
            CORE_RX_PENDING <= 1'b0;
            INSTR_ISSUE     <= 1'b0;
            INSTR_WORD      <= 32'h0000_0000;
            pc_sample       <= 32'h0000_0000;
        end else begin
            pc_sample <= {CORE_PC[31:2], iset_code};
            if (do_mode_wr) begin
                mode <= PWDATA[`DTR_ST_MODE_HI:`DTR_ST_MODE_LO];
            end
            if (do_rx_wr) begin
                CORE_RX_DATA <= PWDATA;
            end
            // new word beats a same-cycle core read
            CORE_RX_PENDING <= do_rx_wr | (CORE_RX_PENDING & ~CORE_RX_READ);
            if (do_itr_wr) begin
                itr <= PWDATA;
            end
            INSTR_ISSUE <= do_issue;
            if (do_issue) begin
                INSTR_WORD <= do_itr_wr ? PWDATA : itr;
                instr_done <= 1'b0;
            end else if (CORE_INSTR_DONE) begin
                instr_done <= 1'b1;
            end
            if (do_status_rd) begin
                rx_latched   <= CORE_RX_PENDING;
                tx_latched   <= tx_pending;
                done_latched <= 1'b1;
            end else begin
                // latched copies track our own accesses until next poll
                if (do_rx_wr) begin
                    rx_latched <= 1'b1;
                end
                if (do_tx_pop) begin
                    tx_latched <= 1'b0;
                end
                if (do_issue) begin
                    done_latched <= 1'b0;
                end
            end
        end
    end

    // sticky flags: same-cycle event beats clear
    always @(posedge CLK) begin
        if (RESET) begin
            sync_abt  <= 1'b0;
            async_abt <= 1'b0;
            undef_exc <= 1'b0;
            pipe_adv  <= 1'b0;
        end else begin
            if (do_run_wr && PWDATA[`DTR_RC_CLR_EXC]) begin
                sync_abt  <= CORE_SYNC_ABT_EVT;
                async_abt <= CORE_ASYNC_ABT_EVT;
                undef_exc <= CORE_UNDEF_EVT;
            end else begin
                sync_abt  <= sync_abt | CORE_SYNC_ABT_EVT;
                async_abt <= async_abt | CORE_ASYNC_ABT_EVT;
                undef_exc <= undef_exc | CORE_UNDEF_EVT;
            end
            if (do_run_wr && PWDATA[`DTR_RC_CLR_PIPE]) begin
                pipe_adv <= CORE_PIPE_ADV_EVT;
            end else begin
                pipe_adv <= pipe_adv | CORE_PIPE_ADV_EVT;
            end
        end
    end

    // requests accepted only in the state they change
    always @(posedge CLK) begin
        if (RESET) begin
            HALT_REQ    <= 1'b0;
            RESTART_REQ <= 1'b0;
        end else begin
            if (CORE_HALTED) begin
                HALT_REQ <= 1'b0;
            end else if (do_run_wr && PWDATA[`DTR_RC_HALT]) begin
                HALT_REQ <= 1'b1;
            end
            if (!CORE_HALTED) begin
                RESTART_REQ <= 1'b0;
            end else if (do_run_wr && PWDATA[`DTR_RC_RESTART]) begin
                RESTART_REQ <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire
